// >>> verilog/timer_counter_unit.v
// One 16-bit timer/counter with gating, source select and four modes
`timescale 1ns/100ps
`default_nettype none
`include "timer_mode_defines.vh"
module timer_counter_unit
(
	// Clock and reset
	input  wire        mclk_in,
	input  wire        reset_in,
	// Configuration
	input  wire        gate_in,
	input  wire        src_in,
	input  wire [1:0]  mode_in,
	input  wire        split_in,
	input  wire        run_in,
	input  wire        irq_pin_in,
	input  wire        count_pin_in,
	input  wire        tick_in,
	// Extra run enable for the 8-bit split high byte
	input  wire        hi_run_in,
	// Counter write port
	input  wire        load_lo_in,
	input  wire        load_hi_in,
	input  wire [7:0]  load_data_in,
	// Counter state
	output wire [15:0] count_out,
	output wire        ovf_out,
	output wire        hi_ovf_out
);
	reg  [7:0] lo_q;
	reg  [7:0] hi_q;
	reg        pin_q;
	reg        ovf_q;
	reg        hi_ovf_q;
	wire       fall;
	wire       enable;
	wire       inc;
	wire       hi_inc;
	assign fall   = pin_q & ~count_pin_in;
	assign enable = run_in & (~gate_in | irq_pin_in);
	assign inc    = enable & (src_in ? fall : tick_in);
	assign hi_inc = hi_run_in & tick_in;
	assign count_out  = {hi_q, lo_q};
	assign ovf_out    = ovf_q;
	assign hi_ovf_out = hi_ovf_q;
	always @(posedge mclk_in)
	begin
		pin_q    <= count_pin_in;
		ovf_q    <= 1'b0;
		hi_ovf_q <= 1'b0;
		if (reset_in)
		begin
			lo_q  <= 8'h00;
			hi_q  <= 8'h00;
			pin_q <= 1'b1;
		end
		else
		begin
			if (inc)
			begin
				case (mode_in)
					`MODE_13BIT:
					begin
						// 5-bit prescaler in low byte, upper 8 in high byte
						lo_q[4:0] <= lo_q[4:0] + 5'h01;
						if (lo_q[4:0] == 5'h1F)
						begin
							hi_q  <= hi_q + 8'h01;
							ovf_q <= (hi_q == 8'hFF);
						end
					end
					`MODE_16BIT:
					begin
						{hi_q, lo_q} <= {hi_q, lo_q} + 16'h0001;
						ovf_q        <= ({hi_q, lo_q} == 16'hFFFF);
					end
					`MODE_8BIT_RELOAD:
					begin
						if (lo_q == 8'hFF)
						begin
							lo_q  <= hi_q;
							ovf_q <= 1'b1;
						end
						else
							lo_q <= lo_q + 8'h01;
					end
					default:
					begin
						if (split_in)
						begin
							lo_q  <= lo_q + 8'h01;
							ovf_q <= (lo_q == 8'hFF);
						end
					end
				endcase
			end
			// Split high byte runs on the plain timebase
			if (split_in && (mode_in == `MODE_SPLIT_STOP) && hi_inc)
			begin
				hi_q     <= hi_q + 8'h01;
				hi_ovf_q <= (hi_q == 8'hFF);
			end
			if (load_lo_in)
				lo_q <= load_data_in;
			if (load_hi_in)
				hi_q <= load_data_in;
		end
	end
endmodule
`default_nettype wire

// >>> verilog/timer_mode_defines.vh
// Constants for the timer mode-control block
// Behaviour
// - With the timer-one gate bit set, timer one advances only while its run bit and the interrupt-one pin are both high; with it clear, the run bit alone enables it.
// - With the timer-zero gate bit (bit 3) clear, timer zero advances whenever its run bit is set; with it set, the interrupt-zero pin must also be high.
// - With the timer-zero count source bit (bit 2) clear, timer zero counts the system clock divided by one or twelve as its prescale bit chooses.
// - With the timer-zero count source bit set, timer zero counts once per falling edge on its external count pin.
// - Timer-one mode code 00 makes timer one a 13-bit counter/timer.
// - Timer-one mode code 01 makes timer one a full 16-bit counter/timer.
// - Timer-one mode code 10 makes timer one an 8-bit counter/timer reloaded from its high byte on overflow.
// - Timer-one mode code 11 holds timer one stopped.
// - Timer-zero mode codes 00 to 10 give 13-bit, 16-bit and 8-bit auto-reload, and 11 splits it into two 8-bit counters.
`ifndef TIMER_MODE_DEFINES_VH
`define TIMER_MODE_DEFINES_VH
`define TMS_ADDR        8'h89
`define TMS_RESET       8'h00
`define TMS_T1_GATE     7
`define TMS_T1_SRC      6
`define TMS_T1_MODE_HI  5
`define TMS_T1_MODE_LO  4
`define TMS_T0_GATE     3
`define TMS_T0_SRC      2
`define TMS_T0_MODE_HI  1
`define TMS_T0_MODE_LO  0
`define MODE_13BIT      2'h0
`define MODE_16BIT      2'h1
`define MODE_8BIT_RELOAD 2'h2
`define MODE_SPLIT_STOP 2'h3
`define PRESCALE_DIV    4'hB
`endif

// >>> verilog/timer_mode_control.v
// Mode register and control of both general-purpose timers
`timescale 1ns/100ps
`default_nettype none
`include "timer_mode_defines.vh"
module timer_mode_control
(
	// Clock and reset
	input  wire        mclk_in,
	input  wire        reset_in,
	// Special register port
	input  wire [7:0]  sfr_addr_in,
	input  wire        sfr_wr_in,
	input  wire [7:0]  sfr_wdata_in,
	output wire [7:0]  sfr_rdata_out,
	// Run and prescale controls
	input  wire        timer_zero_run_in,
	input  wire        timer_one_run_in,
	input  wire        timer_zero_clock_prescale_in,
	input  wire        timer_one_clock_prescale_in,
	// Pins
	input  wire        ext_irq_zero_pin_in,
	input  wire        ext_irq_one_pin_in,
	input  wire        timer_zero_count_pin_in,
	input  wire        timer_one_count_pin_in,
	// Counter write ports
	input  wire        t0_load_lo_in,
	input  wire        t0_load_hi_in,
	input  wire        t1_load_lo_in,
	input  wire        t1_load_hi_in,
	input  wire [7:0]  load_data_in,
	// Counter state
	output wire [15:0] timer_zero_count_out,
	output wire [15:0] timer_one_count_out,
	output wire        timer_zero_ovf_out,
	output wire        timer_zero_hi_ovf_out,
	output wire        timer_one_ovf_out
);
	reg  [7:0] mode_q;
	reg  [3:0] div_q;
	wire       div_tick;
	wire       t0_tick;
	wire       t1_tick;
	wire       t0_split;
	wire       t1_run;
	assign sfr_rdata_out = mode_q;
	assign div_tick = (div_q == `PRESCALE_DIV);
	assign t0_tick  = timer_zero_clock_prescale_in | div_tick;
	assign t1_tick  = timer_one_clock_prescale_in | div_tick;
	assign t0_split = (mode_q[`TMS_T0_MODE_HI:`TMS_T0_MODE_LO] == `MODE_SPLIT_STOP);
	// Timer one stops in code 11; split timer zero borrows its run bit
	assign t1_run = timer_one_run_in &
		(mode_q[`TMS_T1_MODE_HI:`TMS_T1_MODE_LO] != `MODE_SPLIT_STOP);
	always @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			mode_q <= `TMS_RESET;
			div_q  <= 4'h0;
		end
		else
		begin
			div_q <= div_tick ? 4'h0 : div_q + 4'h1;
			if (sfr_wr_in && (sfr_addr_in == `TMS_ADDR))
				mode_q <= sfr_wdata_in;
		end
	end
	timer_counter_unit u_timer_zero
	(
		.mclk_in      (mclk_in),
		.reset_in     (reset_in),
		.gate_in      (mode_q[`TMS_T0_GATE]),
		.src_in       (mode_q[`TMS_T0_SRC]),
		.mode_in      (mode_q[`TMS_T0_MODE_HI:`TMS_T0_MODE_LO]),
		.split_in     (1'b1),
		.run_in       (timer_zero_run_in),
		.irq_pin_in   (ext_irq_zero_pin_in),
		.count_pin_in (timer_zero_count_pin_in),
		.tick_in      (t0_tick),
		.hi_run_in    (timer_one_run_in & t0_split),
		.load_lo_in   (t0_load_lo_in),
		.load_hi_in   (t0_load_hi_in),
		.load_data_in (load_data_in),
		.count_out    (timer_zero_count_out),
		.ovf_out      (timer_zero_ovf_out),
		.hi_ovf_out   (timer_zero_hi_ovf_out)
	);
	timer_counter_unit u_timer_one
	(
		.mclk_in      (mclk_in),
		.reset_in     (reset_in),
		.gate_in      (mode_q[`TMS_T1_GATE]),
		.src_in       (mode_q[`TMS_T1_SRC]),
		.mode_in      (mode_q[`TMS_T1_MODE_HI:`TMS_T1_MODE_LO]),
		.split_in     (1'b0),
		.run_in       (t1_run),
		.irq_pin_in   (ext_irq_one_pin_in),
		.count_pin_in (timer_one_count_pin_in),
		.tick_in      (t1_tick),
		.hi_run_in    (1'b0),
		.load_lo_in   (t1_load_lo_in),
		.load_hi_in   (t1_load_hi_in),
		.load_data_in (load_data_in),
		.count_out    (timer_one_count_out),
		.ovf_out      (timer_one_ovf_out),
		.hi_ovf_out   ()
	);
endmodule
`default_nettype wire

// >>> verification/timer_mode_monitor.sv
// Checker for the timer mode block
`timescale 1ns/100ps
`default_nettype none
module timer_mode_monitor (
	input wire logic        mclk_in, reset_in, sfr_wr_in, timer_zero_run_in, timer_one_run_in,
	input wire logic        timer_zero_clock_prescale_in, timer_one_clock_prescale_in,
	input wire logic        ext_irq_zero_pin_in, ext_irq_one_pin_in, t0_load_lo_in,
	input wire logic        t0_load_hi_in, t1_load_lo_in, t1_load_hi_in,
	input wire logic [7:0]  sfr_addr_in, sfr_wdata_in, sfr_rdata_out,
	input wire logic [15:0] timer_zero_count_out, timer_one_count_out
);
	wire [7:0]  m = sfr_rdata_out;
	wire [15:0] c0 = timer_zero_count_out;
	wire [15:0] c1 = timer_one_count_out;
	wire        n0 = !(t0_load_lo_in || t0_load_hi_in);
	wire        n1 = !(t1_load_lo_in || t1_load_hi_in);
	wire        r1 = timer_one_run_in && timer_one_clock_prescale_in && n1;
	wire        wr = sfr_wr_in && sfr_addr_in == 8'h89;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	a_reg_write: assert property (wr |=> m == $past(sfr_wdata_in))
		else $error("mode write lost");
	a_reg_hold: assert property (!wr |=> $stable(m))
		else $error("mode changed");
	a_t1_gate: assert property (m[7] && !ext_irq_one_pin_in && n1 |=> $stable(c1))
		else $error("timer one ran gated");
	a_t0_gate: assert property (m[3] && m[1:0] != 2'h3 && !ext_irq_zero_pin_in && n0
		|=> $stable(c0))
		else $error("timer zero ran gated");
	a_t1_stop: assert property (m[5:4] == 2'h3 && n1 |=> $stable(c1))
		else $error("timer one ran stopped");
	a_t1_full: assert property (m[7:4] == 4'h1 && r1 |=> c1 == $past(c1) + 16'h1)
		else $error("timer one step");
	a_t1_reload: assert property (m[7:4] == 4'h2 && r1 && c1[7:0] == 8'hFF
		|=> c1[7:0] == c1[15:8])
		else $error("timer one reload");
	a_t1_short: assert property (m[7:4] == 4'h0 && r1 && c1[4:0] == 5'h1F
		|=> c1[4:0] == 5'h0 && c1[15:8] == $past(c1[15:8]) + 8'h1)
		else $error("timer one 13-bit carry");
	a_t0_full: assert property (m[3:0] == 4'h1 && timer_zero_run_in && n0
		&& timer_zero_clock_prescale_in |=> c0 == $past(c0) + 16'h1)
		else $error("timer zero step");
endmodule
bind timer_mode_control timer_mode_monitor mon (.*);
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the timer mode block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        mclk_in = 0, reset_in = 1, sfr_wr_in = 0, timer_zero_run_in = 0;
	logic        timer_one_run_in = 0, timer_zero_clock_prescale_in = 1;
	logic        timer_one_clock_prescale_in = 1, ext_irq_zero_pin_in = 1, ext_irq_one_pin_in = 1;
	logic        timer_zero_count_pin_in = 1, timer_one_count_pin_in = 1, t0_load_lo_in = 0;
	logic        t0_load_hi_in = 0, t1_load_lo_in = 0, t1_load_hi_in = 0;
	logic [7:0]  sfr_addr_in = 8'h89, sfr_wdata_in = 8'h00, load_data_in = 8'h00, sfr_rdata_out;
	logic [15:0] timer_zero_count_out, timer_one_count_out;
	logic        timer_zero_ovf_out, timer_zero_hi_ovf_out, timer_one_ovf_out;
	int          error_cnt = 0, total_checks = 0;
	timer_mode_control DUT (.*);
	initial forever #10 mclk_in = ~mclk_in;
	task automatic cyc(int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rst();
		reset_in = 1;
		cyc(2);
		reset_in = 0;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1;
		cyc(1);
		sfr_wr_in = 0;
		cyc(1);
	endtask
	task automatic ld1(logic [7:0] h, logic [7:0] l);
		load_data_in = l;
		t1_load_lo_in = 1;
		cyc(1);
		t1_load_lo_in = 0;
		load_data_in = h;
		t1_load_hi_in = 1;
		cyc(1);
		t1_load_hi_in = 0;
	endtask
	task automatic ld0(logic [7:0] h, logic [7:0] l);
		load_data_in = l;
		t0_load_lo_in = 1;
		cyc(1);
		t0_load_lo_in = 0;
		load_data_in = h;
		t0_load_hi_in = 1;
		cyc(1);
		t0_load_hi_in = 0;
	endtask
	task automatic run(bit a, bit b, int n);
		timer_zero_run_in = a;
		timer_one_run_in = b;
		cyc(n);
		timer_zero_run_in = 0;
		timer_one_run_in = 0;
		cyc(1);
	endtask
	task automatic t_reg();
		chk("mode", 16'h0000, sfr_rdata_out);
		wr(8'h89, 8'hA5);
		chk("mode", 16'h00A5, sfr_rdata_out);
		wr(8'h88, 8'h3C);
		chk("mode", 16'h00A5, sfr_rdata_out);
		$display("t_reg done");
	endtask
	task automatic t_t1();
		rst();
		wr(8'h89, 8'h20);
		ld1(8'hF0, 8'hFE);
		timer_one_run_in = 1;
		cyc(2);
		chk("t1 ovf", 16'h0001, timer_one_ovf_out);
		cyc(1);
		chk("t1 ovf", 16'h0000, timer_one_ovf_out);
		timer_one_run_in = 0;
		cyc(1);
		chk("t1", 16'hF0F1, timer_one_count_out);
		wr(8'h89, 8'h30);
		run(0, 1, 4);
		chk("t1", 16'hF0F1, timer_one_count_out);
		wr(8'h89, 8'h10);
		ld1(8'h00, 8'hFF);
		run(0, 1, 1);
		chk("t1", 16'h0100, timer_one_count_out);
		wr(8'h89, 8'h00);
		ld1(8'h00, 8'h1F);
		run(0, 1, 1);
		chk("t1", 16'h0100, timer_one_count_out);
		$display("t_t1 done");
	endtask
	task automatic t_gate();
		rst();
		wr(8'h89, 8'h99);
		ext_irq_zero_pin_in = 0;
		ext_irq_one_pin_in = 0;
		run(1, 1, 4);
		ext_irq_zero_pin_in = 1;
		ext_irq_one_pin_in = 1;
		run(1, 1, 4);
		chk("t0", 16'h0004, timer_zero_count_out);
		chk("t1", 16'h0004, timer_one_count_out);
		$display("t_gate done");
	endtask
	task automatic t_src();
		rst();
		wr(8'h89, 8'h01);
		timer_zero_clock_prescale_in = 0;
		run(1, 0, 24);
		timer_zero_clock_prescale_in = 1;
		run(1, 0, 2);
		chk("t0", 16'h0004, timer_zero_count_out);
		rst();
		wr(8'h89, 8'h55);
		timer_zero_run_in = 1;
		timer_one_run_in = 1;
		repeat (3)
		begin
			timer_zero_count_pin_in = 0;
			timer_one_count_pin_in = 0;
			cyc(2);
			timer_zero_count_pin_in = 1;
			timer_one_count_pin_in = 1;
			cyc(2);
		end
		run(0, 0, 3);
		chk("t0", 16'h0003, timer_zero_count_out);
		chk("t1", 16'h0003, timer_one_count_out);
		$display("t_src done");
	endtask
	task automatic t_split();
		rst();
		wr(8'h89, 8'h02);
		ld0(8'h30, 8'hFF);
		run(1, 0, 2);
		chk("t0", 16'h3031, timer_zero_count_out);
		wr(8'h89, 8'h00);
		ld0(8'h00, 8'h1F);
		run(1, 0, 1);
		chk("t0", 16'h0100, timer_zero_count_out);
		wr(8'h89, 8'h03);
		ld0(8'hFE, 8'hFE);
		timer_zero_run_in = 1;
		timer_one_run_in = 1;
		cyc(2);
		chk("t0 ovf", 16'h0001, timer_zero_ovf_out);
		chk("t0 hi ovf", 16'h0001, timer_zero_hi_ovf_out);
		cyc(1);
		chk("t0 ovf", 16'h0000, timer_zero_ovf_out);
		chk("t0 hi ovf", 16'h0000, timer_zero_hi_ovf_out);
		cyc(1);
		timer_zero_run_in = 0;
		timer_one_run_in = 0;
		chk("t0", 16'h0202, timer_zero_count_out);
		chk("t1", 16'h0004, timer_one_count_out);
		$display("t_split done");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		cyc(8);
		reset_in = 0;
		t_reg();
		t_t1();
		t_gate();
		t_src();
		t_split();
		test_done();
	end
	initial
	begin
		#100000;
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
